// >>> dv/ogm_host_model.sv
`timescale 1ns/100ps
`include "ogm_consts.svh"

module ogm_host_model (
   input  wire logic                  clk_in,     // System clock
   input  wire ogm_pkg::ogm_byte_type rdata_in,   // Read data from the block
   output logic                       wr_out,     // Write strobe
   output logic                       rd_out,     // Read strobe
   output ogm_pkg::ogm_byte_type      addr_out,   // Register address
   output ogm_pkg::ogm_byte_type      wdata_out   // Write data
);
   import ogm_pkg::*;

   // Released lines show the inverse of their last value
   initial begin
      wr_out    = 1'b0;
      rd_out    = 1'b0;
      addr_out  = 8'h55;
      wdata_out = 8'hAA;
   end

   // One byte per access, written at the base address
   task automatic write_reg(input ogm_byte_type addr, input ogm_byte_type data);
      @(posedge clk_in);
      #1;
      wr_out    = 1'b1;
      addr_out  = addr;
      wdata_out = data;
      @(posedge clk_in);
      #1;
      wr_out    = 1'b0;
      addr_out  = ~addr_out;
      wdata_out = ~wdata_out;
   endtask

   // Read at base plus the read flag, data taken after the following edge
   task automatic read_reg(input ogm_byte_type addr, output ogm_byte_type data);
      @(posedge clk_in);
      #1;
      rd_out   = 1'b1;
      addr_out = addr | `OGM_READ_FLAG;
      @(posedge clk_in);
      #1;
      rd_out   = 1'b0;
      addr_out = ~addr_out;
      @(posedge clk_in);
      #1;
      data = rdata_in;
   endtask
endmodule // ogm_host_model

// >>> dv/tb_ogm_glyph_access.sv
`timescale 1ns/100ps
`include "ogm_consts.svh"
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end

module tb_ogm_glyph_access;
   import ogm_pkg::*;
   localparam int unsigned PROG_N = 20;
   localparam int unsigned LOAD_N = `OGM_LOAD_CYCLES;

   logic         clk_in        = 1'b0;
   logic         arst_n_in     = 1'b0;
   logic         osd_enable_in = 1'b0;
   logic         reg_wr;
   logic         reg_rd;
   logic         store_busy;
   ogm_byte_type reg_addr;
   ogm_byte_type reg_wdata;
   ogm_byte_type reg_rdata;
   ogm_byte_type rd_val;
   int           num_errors      = 0;
   int           samples_checked = 0;
   int           n;

   always #5 clk_in = ~clk_in;

   ogm_host_model host_u (
      .clk_in(clk_in), .rdata_in(reg_rdata), .wr_out(reg_wr), .rd_out(reg_rd),
      .addr_out(reg_addr), .wdata_out(reg_wdata)
   );

   ogm_glyph_access #(.PROG_CYCLES(PROG_N)) dut_u (
      .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
      .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .osd_enable_in(osd_enable_in),
      .reg_rdata_out(reg_rdata), .store_busy_out(store_busy)
   );

   // ***************************************************************
   // Helpers
   // ***************************************************************
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check_reg(input ogm_byte_type addr, input ogm_byte_type exp);
      host_u.read_reg(addr, rd_val);
      `CHK(rd_val, exp)
   endtask

   // Counts the cycles for which busy is still seen high
   task automatic busy_len(input int exp);
      n = 0;
      while (store_busy === 1'b1 && n < 2000) begin
         n++;
         @(posedge clk_in);
         #1;
      end
      `CHK(n, exp)
   endtask

   // ***************************************************************
   // Tests
   // ***************************************************************
   initial begin
      repeat (10) @(posedge clk_in);
      #1;
      arst_n_in = 1'b1;
      `CHK(store_busy, 1'b0)
      for (int a = 8; a <= 12; a++) check_reg(8'(a), 8'h00);
      host_u.write_reg(8'h09, 8'h3C);
      host_u.write_reg(8'h0A, 8'hC5);
      host_u.write_reg(8'h0B, 8'h8D);
      host_u.write_reg(8'h0C, 8'hFF);
      check_reg(8'h09, 8'h3C);
      check_reg(8'h0A, 8'hC5);
      check_reg(8'h0B, 8'h8D);
      check_reg(8'h0C, 8'h00);
      host_u.write_reg(8'h08, 8'h33);
      `CHK(store_busy, 1'b0)
      check_reg(8'h08, 8'h33);
      host_u.write_reg(8'h08, 8'h00);
      for (int i = 0; i < 64; i++) begin
         host_u.write_reg(8'h0A, 8'hC0 | 8'(i));
         host_u.write_reg(8'h0B, 8'(i) ^ 8'h5A);
      end
      check_reg(8'h0A, 8'hFF);
      check_reg(8'h0B, 8'h65);
      host_u.write_reg(8'h09, 8'hFF);
      host_u.write_reg(8'h08, 8'hA7);
      busy_len(PROG_N);
      check_reg(8'h08, 8'h00);
      // Writes during busy are dropped, reads still served
      host_u.write_reg(8'h08, 8'hA1);
      host_u.write_reg(8'h09, 8'h12);
      check_reg(8'h08, 8'hA1);
      check_reg(8'h09, 8'hFF);
      busy_len(PROG_N - 8);
      check_reg(8'h08, 8'h00);
      host_u.write_reg(8'h08, 8'h5C);
      busy_len(LOAD_N);
      check_reg(8'h08, 8'h00);
      // Display on blocks commands and index writes
      osd_enable_in = 1'b1;
      host_u.write_reg(8'h09, 8'h44);
      host_u.write_reg(8'h08, 8'hA0);
      `CHK(store_busy, 1'b0)
      check_reg(8'h09, 8'hFF);
      check_reg(8'h08, 8'h00);
      osd_enable_in = 1'b0;
      host_u.write_reg(8'h0A, 8'h03);
      host_u.write_reg(8'h0B, 8'h00);
      `CHK(dut_u.shadow_q[3], 8'h00)
      host_u.write_reg(8'h08, 8'h50);
      busy_len(LOAD_N);
      `CHK(dut_u.shadow_q[3], 8'h59)
      `CHK(dut_u.shadow_q[63], 8'h65)
      give_verdict();
   end

   initial begin
      repeat (20000) @(posedge clk_in);
      num_errors++;
      give_verdict();
   end
endmodule // tb_ogm_glyph_access

// >>> logic/ogm_glyph_access.sv
`timescale 1ns/100ps
`include "ogm_consts.svh"

// Summary of operation
// - Index, data, command writes need idle, display off
// - Only whole glyphs move between store, shadow
// - Host writes shadow buffer one byte per access
// - Nibble 1010 programs shadow into indexed glyph
// - Program holds busy about twelve milliseconds
// - Program end clears command and busy
// - Nibble 0101 loads indexed glyph into shadow
// - Load busy half microsecond, then auto clear
// - Commands ignored while display on or busy
// - Every register readable at any time
// - Full eight-bit index picks one of 256
// - Low six byte-index bits pick shadow byte
// - Data byte holds four 2-bit pixels, leftmost high
// - Write at base, read at base plus 80h
// - Busy status reads 1 while store unavailable

module ogm_glyph_access #(
   parameter int unsigned PROG_CYCLES = `OGM_PROG_CYCLES // Program busy length in cycles
) (
   input  wire logic                  clk_in,         // System clock, 100 MHz
   input  wire logic                  arst_n_in,      // Asynchronous reset, active low
   input  wire logic                  reg_wr_in,      // Register write strobe
   input  wire logic                  reg_rd_in,      // Register read strobe
   input  wire ogm_pkg::ogm_byte_type reg_addr_in,    // Register address
   input  wire ogm_pkg::ogm_byte_type reg_wdata_in,   // Register write data
   input  wire logic                  osd_enable_in,  // video_mode_control_zero bit 3
   output ogm_pkg::ogm_byte_type      reg_rdata_out,  // Registered read data
   output logic                       store_busy_out  // Store unavailable flag
);
   import ogm_pkg::*;

   localparam int unsigned LOAD_CYCLES = `OGM_LOAD_CYCLES;
   localparam int          LOAD_TAIL_I = LOAD_CYCLES - 1;
   localparam ogm_cnt_type LOAD_LAST   = `OGM_CNT_W'(LOAD_CYCLES - 1);
   localparam ogm_cnt_type PROG_LAST   = `OGM_CNT_W'(PROG_CYCLES - 1);

   // ***************************************************************
   // Address decode
   // ***************************************************************
   function automatic logic reg_hit(input ogm_byte_type addr, input ogm_byte_type base,
                                    input logic rd);
      reg_hit = (addr == (rd ? (base | `OGM_READ_FLAG) : base));
   endfunction

   ogm_state_type state_q;
   ogm_state_type state_d;
   ogm_cnt_type   cnt_q;
   ogm_cnt_type   cnt_d;
   ogm_byte_type  cmd_q;
   ogm_byte_type  cmd_d;
   ogm_gidx_type  gidx_q;
   ogm_gidx_type  gidx_d;
   ogm_byte_type  bidx_q;
   ogm_byte_type  bidx_d;
   ogm_byte_type  pix_q;
   ogm_byte_type  pix_d;
   ogm_byte_type  rdata_q;
   ogm_byte_type  rdata_d;
   logic          busy_q;
   logic          busy_d;
   ogm_byte_type  shadow_q [`OGM_SHADOW_BYTES];
   ogm_row_type   shadow_row;
   ogm_row_type   store_rdata;
   ogm_bidx_type  bsel;
   ogm_byte_type  rd_sel;

   wire wr_ok      = reg_wr_in && !busy_q && !osd_enable_in;
   wire cmd_wr     = wr_ok && reg_hit(reg_addr_in, `OGM_ADDR_CMD, 1'b0);
   wire gidx_wr    = wr_ok && reg_hit(reg_addr_in, `OGM_ADDR_GLYPH_IDX, 1'b0);
   wire bidx_wr    = wr_ok && reg_hit(reg_addr_in, `OGM_ADDR_BYTE_IDX, 1'b0);
   wire pix_wr     = wr_ok && reg_hit(reg_addr_in, `OGM_ADDR_PIXEL, 1'b0);
   wire [`OGM_NIB_MSB:`OGM_NIB_LSB] cmd_nib = reg_wdata_in[`OGM_NIB_MSB:`OGM_NIB_LSB];
   wire start_load = cmd_wr && (cmd_nib == `OGM_NIB_LOAD);
   wire start_prog = cmd_wr && (cmd_nib == `OGM_NIB_PROGRAM);
   wire load_done  = (state_q == OGM_LOAD) && (cnt_q == LOAD_LAST);
   wire prog_done  = (state_q == OGM_PROG) && (cnt_q == PROG_LAST);
   wire op_done    = load_done || prog_done;

   // ***************************************************************
   // Transfer sequencing
   // ***************************************************************
   assign state_d = start_load ? OGM_LOAD :
                    start_prog ? OGM_PROG :
                    op_done    ? OGM_IDLE : state_q;
   assign cnt_d   = (start_load || start_prog || op_done) ? '0 :
                    (state_q != OGM_IDLE) ? cnt_q + 1'b1 : cnt_q;
   assign busy_d  = (start_load || start_prog) ? 1'b1 :
                    op_done ? 1'b0 : busy_q;
   assign cmd_d   = op_done ? `OGM_CMD_RESET :
                    cmd_wr  ? reg_wdata_in : cmd_q;

   // ***************************************************************
   // Index and data registers
   // ***************************************************************
   assign gidx_d = gidx_wr ? reg_wdata_in : gidx_q;
   assign bidx_d = bidx_wr ? reg_wdata_in : bidx_q;
   assign pix_d  = pix_wr  ? reg_wdata_in : pix_q;
   assign bsel   = bidx_q[`OGM_BIDX_W-1:0];

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_q <= OGM_IDLE;
         cnt_q   <= '0;
         busy_q  <= 1'b0;
         cmd_q   <= `OGM_CMD_RESET;
         gidx_q  <= `OGM_IDX_RESET;
         bidx_q  <= `OGM_BIDX_RESET;
         pix_q   <= `OGM_PIXEL_RESET;
         rdata_q <= `OGM_PIXEL_RESET;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         busy_q  <= busy_d;
         cmd_q   <= cmd_d;
         gidx_q  <= gidx_d;
         bidx_q  <= bidx_d;
         pix_q   <= pix_d;
         rdata_q <= rdata_d;
      end
   end

   // ***************************************************************
   // Shadow buffer: byte writes from the host, whole-row fills on load
   // ***************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < `OGM_SHADOW_BYTES; gi++) begin : g_shadow
         wire byte_wr = pix_wr && (bsel == `OGM_BIDX_W'(gi));
         always_ff @(posedge clk_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
               shadow_q[gi] <= `OGM_PIXEL_RESET;
            end else if (load_done) begin
               shadow_q[gi] <= store_rdata[gi*`OGM_BYTE_W +: `OGM_BYTE_W];
            end else if (byte_wr) begin
               shadow_q[gi] <= reg_wdata_in;
            end
         end
         assign shadow_row[gi*`OGM_BYTE_W +: `OGM_BYTE_W] = shadow_q[gi];
      end
   endgenerate

   // ***************************************************************
   // Nonvolatile glyph array
   // ***************************************************************
   ogm_glyph_store u_store (
      .clk_in    (clk_in),
      .wr_en_in  (start_prog),
      .addr_in   (gidx_q),
      .wdata_in  (shadow_row),
      .rdata_out (store_rdata)
   );

   // ***************************************************************
   // Read path, open at all times
   // ***************************************************************
   assign rd_sel = reg_hit(reg_addr_in, `OGM_ADDR_CMD, 1'b1)       ? cmd_q  :
                   reg_hit(reg_addr_in, `OGM_ADDR_GLYPH_IDX, 1'b1) ? gidx_q :
                   reg_hit(reg_addr_in, `OGM_ADDR_BYTE_IDX, 1'b1)  ? bidx_q :
                   reg_hit(reg_addr_in, `OGM_ADDR_PIXEL, 1'b1)     ? pix_q  :
                   `OGM_PIXEL_RESET;
   assign rdata_d = reg_rd_in ? rd_sel : rdata_q;

   assign reg_rdata_out  = rdata_q;
   assign store_busy_out = busy_q;

   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);

   gidx_write_lock_a: assert property (
      (reg_wr_in && reg_hit(reg_addr_in, `OGM_ADDR_GLYPH_IDX, 1'b0) && (busy_q || osd_enable_in))
      |=> $stable(gidx_q))
      else $error("Glyph index changed while locked");

   cmd_ignored_a: assert property (
      (reg_wr_in && reg_hit(reg_addr_in, `OGM_ADDR_CMD, 1'b0) && osd_enable_in && !busy_q)
      |=> $stable(cmd_q) && !busy_q)
      else $error("Command accepted while display on");

   load_length_a: assert property (
      start_load |=> (busy_q throughout ##LOAD_TAIL_I 1'b1)
      ##1 (!busy_q && cmd_q == `OGM_CMD_RESET))
      else $error("Load busy length wrong");

   prog_hold_a: assert property (
      start_prog |=> busy_q[*8] ##0 (state_q == OGM_PROG))
      else $error("Program busy dropped early");

   prog_end_a: assert property (
      prog_done |=> !busy_q && cmd_q == `OGM_CMD_RESET && state_q == OGM_IDLE)
      else $error("Program end did not clear");

   prog_count_a: assert property (
      (state_q == OGM_PROG) |-> (cnt_q <= PROG_LAST) && busy_q)
      else $error("Program counter overran");

   pixel_write_a: assert property (
      pix_wr && !op_done |=> shadow_q[$past(bsel)] == $past(reg_wdata_in))
      else $error("Pixel byte not stored at byte index");

   read_back_a: assert property (
      (reg_rd_in && reg_hit(reg_addr_in, `OGM_ADDR_CMD, 1'b1)) |=> reg_rdata_out == $past(cmd_q))
      else $error("Command read-back wrong");

   busy_status_a: assert property (
      store_busy_out == (state_q != OGM_IDLE))
      else $error("Busy flag disagrees with state");

   bidx_write_lock_a: assert property (
      (reg_wr_in && reg_hit(reg_addr_in, `OGM_ADDR_BYTE_IDX, 1'b0) && (busy_q || osd_enable_in))
      |=> $stable(bidx_q))
      else $error("Byte index changed while locked");

   pixel_write_lock_a: assert property (
      (reg_wr_in && reg_hit(reg_addr_in, `OGM_ADDR_PIXEL, 1'b0) && (busy_q || osd_enable_in)
       && !load_done) |=> $stable(pix_q) && $stable(shadow_row))
      else $error("Pixel data changed while locked");

   busy_cmd_drop_a: assert property (
      (reg_wr_in && reg_hit(reg_addr_in, `OGM_ADDR_CMD, 1'b0) && busy_q && !op_done)
      |=> $stable(cmd_q) && $stable(state_q))
      else $error("Command accepted while busy");

   prog_start_a: assert property (
      start_prog |=> busy_q && state_q == OGM_PROG && cmd_q == $past(reg_wdata_in))
      else $error("Program command not taken");

   load_start_a: assert property (
      start_load |=> busy_q && state_q == OGM_LOAD && cmd_q == $past(reg_wdata_in))
      else $error("Load command not taken");

   prog_store_a: assert property (
      start_prog |=> ##1 store_rdata == $past(shadow_row, 2))
      else $error("Glyph row not programmed from shadow");

   load_fill_a: assert property (
      load_done |=> shadow_row == $past(store_rdata))
      else $error("Shadow not filled from glyph row");

   idx_hold_busy_a: assert property (
      busy_q |=> $stable(gidx_q) && $stable(bidx_q))
      else $error("Index moved during a store operation");

   gidx_full_a: assert property (
      gidx_wr |=> gidx_q == $past(reg_wdata_in))
      else $error("Glyph index not stored in full");

   bidx_full_a: assert property (
      bidx_wr |=> bidx_q == $past(reg_wdata_in))
      else $error("Byte index not stored");

   pixel_reg_a: assert property (
      pix_wr |=> pix_q == $past(reg_wdata_in))
      else $error("Pixel data register not stored");

   load_clear_a: assert property (
      load_done |=> !busy_q && cmd_q == `OGM_CMD_RESET && state_q == OGM_IDLE)
      else $error("Load end did not clear");

   prog_stay_a: assert property (
      (state_q == OGM_PROG && !prog_done) |=> state_q == OGM_PROG && busy_q)
      else $error("Program ended before its count");

   load_count_a: assert property (
      (state_q == OGM_LOAD) |-> (cnt_q <= LOAD_LAST) && busy_q)
      else $error("Load counter overran");

   plain_cmd_a: assert property (
      (cmd_wr && !start_load && !start_prog) |=> !busy_q && cmd_q == $past(reg_wdata_in))
      else $error("Plain command byte not stored");

   read_gidx_a: assert property (
      (reg_rd_in && reg_hit(reg_addr_in, `OGM_ADDR_GLYPH_IDX, 1'b1))
      |=> reg_rdata_out == $past(gidx_q))
      else $error("Glyph index read-back wrong");

   read_bidx_a: assert property (
      (reg_rd_in && reg_hit(reg_addr_in, `OGM_ADDR_BYTE_IDX, 1'b1))
      |=> reg_rdata_out == $past(bidx_q))
      else $error("Byte index read-back wrong");

   read_pixel_a: assert property (
      (reg_rd_in && reg_hit(reg_addr_in, `OGM_ADDR_PIXEL, 1'b1))
      |=> reg_rdata_out == $past(pix_q))
      else $error("Pixel data read-back wrong");

   read_hold_a: assert property (
      !reg_rd_in |=> $stable(reg_rdata_out))
      else $error("Read data moved without a read");

   read_unmapped_a: assert property (
      (reg_rd_in && ((reg_addr_in & `OGM_READ_FLAG) == '0))
      |=> reg_rdata_out == `OGM_PIXEL_RESET)
      else $error("Read at a write address returned data");

   write_at_read_a: assert property (
      (reg_wr_in && reg_hit(reg_addr_in, `OGM_ADDR_CMD, 1'b1) && !busy_q)
      |=> $stable(cmd_q) && !busy_q)
      else $error("Write at read address took effect");

   busy_rise_a: assert property (
      $rose(store_busy_out) |-> $past(cmd_wr))
      else $error("Busy rose without a command");

   busy_fall_a: assert property (
      $fell(store_busy_out) |-> cmd_q == `OGM_CMD_RESET)
      else $error("Busy fell with command still set");

endmodule // ogm_glyph_access

// >>> logic/ogm_glyph_store.sv
`timescale 1ns/100ps
`include "ogm_consts.svh"

module ogm_glyph_store (
   input  wire logic                clk_in,      // System clock
   input  wire logic                wr_en_in,    // Write whole glyph row
   input  wire ogm_pkg::ogm_gidx_type addr_in,   // Glyph select
   input  wire ogm_pkg::ogm_row_type  wdata_in,  // Row to store
   output ogm_pkg::ogm_row_type       rdata_out  // Registered row read
);
   import ogm_pkg::*;

   // ***************************************************************
   // Nonvolatile glyph array, one 64-byte row per glyph
   // ***************************************************************
   ogm_row_type mem_q [`OGM_GLYPH_COUNT];
   ogm_row_type rdata_q;

   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         mem_q[addr_in] <= wdata_in;
      end
      rdata_q <= mem_q[addr_in];
   end

   assign rdata_out = rdata_q;

endmodule // ogm_glyph_store

// >>> pkg/ogm_consts.svh
`ifndef OGM_CONSTS_SVH
`define OGM_CONSTS_SVH

// ***************************************************************
// Register write addresses; a read uses the same address plus the flag
// ***************************************************************
`define OGM_ADDR_CMD        8'h08
`define OGM_ADDR_GLYPH_IDX  8'h09
`define OGM_ADDR_BYTE_IDX   8'h0A
`define OGM_ADDR_PIXEL      8'h0B
`define OGM_READ_FLAG       8'h80

// ***************************************************************
// Reset values and command nibbles
// ***************************************************************
`define OGM_CMD_RESET       8'h00
`define OGM_IDX_RESET       8'h00
`define OGM_BIDX_RESET      8'h00
`define OGM_PIXEL_RESET     8'h00
`define OGM_NIB_PROGRAM     4'hA
`define OGM_NIB_LOAD        4'h5
`define OGM_NIB_MSB         7
`define OGM_NIB_LSB         4

// ***************************************************************
// Geometry
// ***************************************************************
`define OGM_BYTE_W          8
`define OGM_GLYPH_COUNT     256
`define OGM_GLYPH_IDX_W     8
`define OGM_SHADOW_BYTES    64
`define OGM_GLYPH_USED      54
`define OGM_BIDX_W          6
`define OGM_ROW_W           512
`define OGM_CNT_W           21

// ***************************************************************
// Timing
// ***************************************************************
`define OGM_CLK_PERIOD_NS   10
`define OGM_LOAD_TIME_NS    500
`define OGM_PROG_TIME_MS    12
`define OGM_NS_PER_MS       1000000
`define OGM_LOAD_CYCLES     (`OGM_LOAD_TIME_NS / `OGM_CLK_PERIOD_NS)
`define OGM_PROG_CYCLES     (`OGM_PROG_TIME_MS * `OGM_NS_PER_MS / `OGM_CLK_PERIOD_NS)

`endif

// >>> pkg/ogm_pkg.sv
`include "ogm_consts.svh"

package ogm_pkg;

   typedef logic [`OGM_BYTE_W-1:0]      ogm_byte_type;
   typedef logic [`OGM_BIDX_W-1:0]      ogm_bidx_type;
   typedef logic [`OGM_GLYPH_IDX_W-1:0] ogm_gidx_type;
   typedef logic [`OGM_ROW_W-1:0]       ogm_row_type;
   typedef logic [`OGM_CNT_W-1:0]       ogm_cnt_type;

   typedef enum logic [1:0] {
      OGM_IDLE,
      OGM_LOAD,
      OGM_PROG
   } ogm_state_type;

endpackage : ogm_pkg
